/* File: hdl/led_decode_keyscan.sv */
// digit decode, key readback with interrupt, self addressing and led self-test logic
`timescale 1ns/1ps
// What this block does
// - per-digit decode enable, bit n for digit n
// - feature bit 2 picks code-B or hex
// - decoder uses low nibble, ignores bits 6:4
// - bit 7 drives decimal point except during optical test, which lights it
// - undecoded digit maps bits straight to segments
// - address bits from segment G and F nodes
// - address is all zero after power-up
// - broadcast write switches to strap address
// - strap nodes left out of keys, undebounced
// - key state updates only after debounce period
// - key state change pulls interrupt low
// - key state read releases interrupt
// - key bits DP..G, pressed reads zero
// - keys not updated while blinking enabled
// - test bit 0 lights all digits
// - bits 1 and 2 start short/open test
// - bit 3 shows test in progress
// - bit 4 shows last test found fault
// - bits 5 and 6 show resistor faults
// - tests leave digit and control registers alone
// - eight per-digit diagnostic result registers
module led_decode_keyscan #(
	parameter int unsigned DEBOUNCE_CYCLES   = led_decode_pkg::DEBOUNCE_CYCLES,
	parameter int unsigned TEST_STEP_CYCLES  = led_decode_pkg::TEST_STEP_CYCLES,
	parameter logic [4:0]  FACTORY_ADDR_BASE = 5'h0a, // arbitrary value
	parameter logic [4:0]  USER_ADDR_BASE    = 5'h15  // arbitrary value
) (
	// clock and reset
	input  wire logic                        CLOCK,
	input  wire logic                        SYS_RST,
	// register access
	input  wire led_decode_pkg::reg_access_t REG,
	output logic [7:0]                       REG_RDATA,
	// display path
	input  wire logic [7:0]                  FEATURE,
	input  wire logic [2:0]                  SCAN_DIGIT,
	input  wire logic [7:0]                  DIGIT_DATA,
	output logic [7:0]                       SEGMENTS,
	output logic                             OPTICAL_TEST,
	// key readback, interrupt and bus address
	input  wire led_decode_pkg::key_sense_t  KEY_SENSE,
	output logic                             IRQ_N_OUT,
	output logic                             IRQ_N_OE,
	output logic [6:0]                       BUS_ADDRESS,
	// led self-test
	input  wire led_decode_pkg::led_sense_t  LED_SENSE,
	input  wire logic                        RES_OPEN_SENSE,
	input  wire logic                        RES_SHORT_SENSE,
	output logic                             TEST_ACTIVE,
	output logic [2:0]                       TEST_DIGIT
);

	localparam logic [led_decode_pkg::DEB_CNT_W-1:0] DEB_LAST =
		led_decode_pkg::DEB_CNT_W'(DEBOUNCE_CYCLES - 1);
	localparam logic [led_decode_pkg::STEP_CNT_W-1:0] STEP_LAST =
		led_decode_pkg::STEP_CNT_W'(TEST_STEP_CYCLES - 1);

	led_decode_pkg::state_t s;
	led_decode_pkg::state_t next_s;

	// ==========================================================
	// font table, segments A..G in bits 6..0
	function automatic logic [6:0] font(input logic [3:0] nib, input logic hex);
		logic [6:0] seg;
		seg = 7'h00;
		case (nib)
			4'h0: seg = 7'h7e;
			4'h1: seg = 7'h30;
			4'h2: seg = 7'h6d;
			4'h3: seg = 7'h79;
			4'h4: seg = 7'h33;
			4'h5: seg = 7'h5b;
			4'h6: seg = 7'h5f;
			4'h7: seg = 7'h70;
			4'h8: seg = 7'h7f;
			4'h9: seg = 7'h7b;
			4'ha: seg = hex ? 7'h77 : 7'h01;
			4'hb: seg = hex ? 7'h1f : 7'h4f;
			4'hc: seg = hex ? 7'h4e : 7'h37;
			4'hd: seg = hex ? 7'h3d : 7'h0e;
			4'he: seg = hex ? 7'h4f : 7'h67;
			4'hf: seg = hex ? 7'h47 : 7'h00;
			default: seg = 7'h00;
		endcase
		return seg;
	endfunction

	logic       wr_decode;
	logic       wr_test;
	logic       wr_config;
	logic       rd_key;
	logic       test_start;
	logic [7:0] test_read;

	// ==========================================================
	// access decode
	assign wr_decode  = REG.wr && (REG.addr == led_decode_pkg::ADDR_DECODE_SELECT);
	assign wr_test    = REG.wr && (REG.addr == led_decode_pkg::ADDR_TEST_CONTROL);
	assign wr_config  = REG.wr && (REG.addr == led_decode_pkg::ADDR_BUS_CONFIG);
	assign rd_key     = REG.rd && ((REG.addr == led_decode_pkg::ADDR_KEY_LOW)
		|| (REG.addr == led_decode_pkg::ADDR_KEY_HIGH));
	assign test_start = wr_test && (s.test_phase == led_decode_pkg::TEST_IDLE)
		&& (REG.wdata[led_decode_pkg::TEST_SHORT_BIT] || REG.wdata[led_decode_pkg::TEST_OPEN_BIT]);
	assign test_read  = {1'b0, s.res_short, s.res_open, s.fault_flag,
		(s.test_phase == led_decode_pkg::TEST_RUN), s.open_sel, s.short_sel, s.optical};

	// ==========================================================
	// next state
	always_comb
	begin
		logic [15:0]     raw;
		logic [7:0][7:0] pend_now;
		raw      = {KEY_SENSE.high, KEY_SENSE.low};
		pend_now = s.pend;
		next_s   = s;

		// register reads, captured one cycle later
		if (REG.rd)
		begin
			if (REG.addr == led_decode_pkg::ADDR_DECODE_SELECT)
				next_s.rdata = s.decode_select;
			else if (REG.addr == led_decode_pkg::ADDR_TEST_CONTROL)
				next_s.rdata = test_read;
			else if (REG.addr >= led_decode_pkg::ADDR_DIAG_FIRST && REG.addr <= led_decode_pkg::ADDR_DIAG_LAST)
				next_s.rdata = s.diag[REG.addr[2:0] - 3'h4];
			else if (REG.addr == led_decode_pkg::ADDR_KEY_LOW)
				next_s.rdata = s.key_state[7:0];
			else if (REG.addr == led_decode_pkg::ADDR_KEY_HIGH)
				next_s.rdata = s.key_state[15:8];
			else
				next_s.rdata = 8'h00;
		end
		if (rd_key)
			next_s.irq_low = 1'b0;

		// decode enable register
		if (wr_decode)
			next_s.decode_select = REG.wdata;

		// test control writes
		if (wr_test)
		begin
			next_s.optical = REG.wdata[led_decode_pkg::TEST_OPTICAL_BIT];
			if (s.test_phase == led_decode_pkg::TEST_IDLE)
			begin
				next_s.short_sel = REG.wdata[led_decode_pkg::TEST_SHORT_BIT];
				next_s.open_sel  = REG.wdata[led_decode_pkg::TEST_OPEN_BIT];
			end
		end
		if (test_start)
		begin
			next_s.test_phase = led_decode_pkg::TEST_RUN;
			next_s.test_digit = 3'h0;
			next_s.step_cnt   = '0;
			next_s.pend       = '0;
		end

		// test sequencer, one step per digit, results held apart until done
		case (s.test_phase)
			led_decode_pkg::TEST_RUN:
			begin
				if (s.step_cnt == STEP_LAST)
				begin
					next_s.step_cnt = '0;
					pend_now[s.test_digit] = (s.open_sel ? LED_SENSE.open_fault : 8'h00)
						| (s.short_sel ? LED_SENSE.short_fault : 8'h00);
					next_s.pend = pend_now;
					next_s.test_digit = s.test_digit + 3'h1;
					if (s.test_digit == 3'h7)
					begin
						next_s.test_phase = led_decode_pkg::TEST_IDLE;
						next_s.diag       = pend_now;
						next_s.fault_flag = |pend_now;
					end
				end
				else
					next_s.step_cnt = s.step_cnt + 1'b1;
			end
			default:
				next_s.step_cnt = '0;
		endcase

		// resistor checks follow the sense inputs
		next_s.res_open  = RES_OPEN_SENSE;
		next_s.res_short = RES_SHORT_SENSE;

		// self addressing, straps taken raw with no debounce
		if (wr_config)
		begin
			next_s.self_addr_used = 1'b1;
			next_s.user_addr_sel  = REG.wdata[led_decode_pkg::ADDR_SELECT_BIT];
			next_s.strap = {KEY_SENSE.low[led_decode_pkg::STRAP_A1_BIT],
				KEY_SENSE.low[led_decode_pkg::STRAP_A0_BIT]};
		end
		if (s.self_addr_used)
			raw[1:0] = 2'b11;

		// debounce: hold off until scan data stays put
		if (raw != s.key_sample)
		begin
			next_s.key_sample = raw;
			next_s.deb_cnt    = '0;
		end
		else if (s.deb_cnt != DEB_LAST)
			next_s.deb_cnt = s.deb_cnt + 1'b1;
		else if (!FEATURE[led_decode_pkg::FEATURE_BLINK_BIT] && (raw != s.key_state))
		begin
			next_s.key_state = raw;
			next_s.irq_low   = 1'b1;
		end

		// segment drive
		if (s.optical)
			next_s.segments = 8'hff;
		else if (s.decode_select[SCAN_DIGIT])
			next_s.segments = {DIGIT_DATA[led_decode_pkg::DP_BIT],
				font(DIGIT_DATA[3:0], FEATURE[led_decode_pkg::FEATURE_FONT_BIT])};
		else
			next_s.segments = DIGIT_DATA;
	end

	// ==========================================================
	// state register
	always_ff @(posedge CLOCK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			s               <= '0;
			s.decode_select <= led_decode_pkg::DECODE_SELECT_RESET;
			s.key_state     <= led_decode_pkg::KEY_STATE_RESET;
			s.key_sample    <= led_decode_pkg::KEY_STATE_RESET;
		end
		else
			s <= next_s;
	end

	// ==========================================================
	// outputs
	assign REG_RDATA    = s.rdata;
	assign SEGMENTS     = s.segments;
	assign OPTICAL_TEST = s.optical;
	assign IRQ_N_OUT    = 1'b0;
	assign IRQ_N_OE     = s.irq_low;
	assign TEST_ACTIVE  = (s.test_phase == led_decode_pkg::TEST_RUN);
	assign TEST_DIGIT   = s.test_digit;
	assign BUS_ADDRESS  = !s.self_addr_used ? led_decode_pkg::BUS_ADDRESS_RESET
		: {(s.user_addr_sel ? USER_ADDR_BASE : FACTORY_ADDR_BASE), s.strap};

	// ==========================================================
	// checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);

	a_irq_on_change: assert property ((s.key_state != $past(s.key_state)) |-> IRQ_N_OE)
		else $error("key state changed without interrupt");
	a_irq_read_release: assert property ((rd_key ##1 (s.key_state == $past(s.key_state))) |-> !IRQ_N_OE)
		else $error("interrupt not released by key read");
	a_key_debounced: assert property ((s.key_state != $past(s.key_state))
		|-> ($past(s.deb_cnt) == DEB_LAST && !$past(FEATURE[led_decode_pkg::FEATURE_BLINK_BIT])))
		else $error("key state updated before debounce or while blinking");
	a_font_eight: assert property ((!s.optical && s.decode_select[SCAN_DIGIT] && DIGIT_DATA[3:0] == 4'h8)
		|=> SEGMENTS[6:0] == 7'h7f)
		else $error("decoded eight wrong");
	a_dp_follows: assert property (!s.optical |=> SEGMENTS[7] == $past(DIGIT_DATA[7]))
		else $error("decimal point does not follow bit 7");
	a_raw_map: assert property ((!s.optical && !s.decode_select[SCAN_DIGIT]) |=> SEGMENTS == $past(DIGIT_DATA))
		else $error("undecoded digit not passed through");
	a_optical_lit: assert property ((wr_test && REG.wdata[0]) |=> ##1 SEGMENTS == 8'hff)
		else $error("optical test does not light segments");
	a_strap_capture: assert property (wr_config |=> BUS_ADDRESS[1:0] == $past(KEY_SENSE.low[1:0]))
		else $error("strap address not captured");
	a_strap_excluded: assert property (s.self_addr_used |-> s.key_state[1:0] == 2'b11)
		else $error("strap nodes reach key state");
	a_test_busy: assert property (test_start |=> TEST_ACTIVE [*8])
		else $error("test not held busy");
	a_fault_commit: assert property ($fell(TEST_ACTIVE) |-> s.fault_flag == (|s.diag))
		else $error("fault flag disagrees with results");
	a_decode_hold: assert property (!wr_decode |=> $stable(s.decode_select))
		else $error("decode select changed without write");
	// freeze, refusal, end of test and resistor flag checks
	a_blink_freeze: assert property (FEATURE[led_decode_pkg::FEATURE_BLINK_BIT] |=> $stable(s.key_state))
		else $error("key state updated while blinking");
	a_test_no_restart: assert property ((wr_test && TEST_ACTIVE) |=> ($stable(s.open_sel)
		&& $stable(s.short_sel)))
		else $error("test selection changed while running");
	a_test_end: assert property ($fell(TEST_ACTIVE) |-> $past(s.test_digit) == 3'h7)
		else $error("test ended before the last digit");
	a_res_follow: assert property (1'b1 |=> (s.res_open == $past(RES_OPEN_SENSE))
		&& (s.res_short == $past(RES_SHORT_SENSE)))
		else $error("resistor flags do not follow the checks");

	// main scenarios
	c_key_irq: cover property (rd_key && IRQ_N_OE);
	c_test_done: cover property ($fell(TEST_ACTIVE) && s.fault_flag);
	c_self_addr: cover property (wr_config && REG.wdata[0]);
	c_hex_font: cover property (s.decode_select[SCAN_DIGIT] && FEATURE[2] && DIGIT_DATA[3:0] == 4'ha);

endmodule // led_decode_keyscan

/* File: hdl/led_decode_pkg.sv */
// constants, carriers and state layout of the digit decode, key readback and test_in_progress block
package led_decode_pkg;

	// ==========================================================
	// clock and timing
	localparam int unsigned CLOCK_HZ         = 10_000_000;
	localparam int unsigned DEBOUNCE_TIME_MS = 20;
	localparam int unsigned DEBOUNCE_CYCLES  = DEBOUNCE_TIME_MS * (CLOCK_HZ / 1000);
	localparam int unsigned TEST_STEP_CYCLES = 16;
	localparam int unsigned DEB_CNT_W        = 20;
	localparam int unsigned STEP_CNT_W       = 8;

	// ==========================================================
	// register offsets
	localparam logic [7:0] ADDR_DECODE_SELECT = 8'h09;
	localparam logic [7:0] ADDR_TEST_CONTROL  = 8'h0f;
	localparam logic [7:0] ADDR_DIAG_FIRST    = 8'h14;
	localparam logic [7:0] ADDR_DIAG_LAST     = 8'h1b;
	localparam logic [7:0] ADDR_KEY_LOW       = 8'h1c;
	localparam logic [7:0] ADDR_KEY_HIGH      = 8'h1d;
	localparam logic [7:0] ADDR_BUS_CONFIG    = 8'h2d;

	// ==========================================================
	// field positions
	localparam int unsigned TEST_OPTICAL_BIT  = 0;
	localparam int unsigned TEST_SHORT_BIT    = 1;
	localparam int unsigned TEST_OPEN_BIT     = 2;
	localparam int unsigned TEST_BUSY_BIT     = 3;
	localparam int unsigned TEST_FAULT_BIT    = 4;
	localparam int unsigned TEST_RES_OPEN_BIT = 5;
	localparam int unsigned TEST_RES_SHORT_BIT = 6;
	localparam int unsigned FEATURE_FONT_BIT  = 2;
	localparam int unsigned FEATURE_BLINK_BIT = 4;
	localparam int unsigned ADDR_SELECT_BIT   = 0;
	localparam int unsigned STRAP_A0_BIT      = 0;
	localparam int unsigned STRAP_A1_BIT      = 1;
	localparam int unsigned DP_BIT            = 7;

	// ==========================================================
	// reset values
	localparam logic [7:0]  DECODE_SELECT_RESET = 8'h00;
	localparam logic [15:0] KEY_STATE_RESET     = 16'hffff;
	localparam logic [6:0]  BUS_ADDRESS_RESET   = 7'h00;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_access_t;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} key_sense_t;

	typedef struct packed {
		logic [7:0] open_fault;
		logic [7:0] short_fault;
	} led_sense_t;

	typedef enum logic [0:0] {TEST_IDLE, TEST_RUN} test_phase_t;

	// ==========================================================
	// whole state of the block
	typedef struct packed {
		logic [7:0]            decode_select;
		logic                  optical;
		logic                  short_sel;
		logic                  open_sel;
		test_phase_t           test_phase;
		logic                  fault_flag;
		logic [STEP_CNT_W-1:0] step_cnt;
		logic [2:0]            test_digit;
		logic [7:0][7:0]       pend;
		logic [7:0][7:0]       diag;
		logic                  res_open;
		logic                  res_short;
		logic [15:0]           key_sample;
		logic [DEB_CNT_W-1:0]  deb_cnt;
		logic [15:0]           key_state;
		logic                  irq_low;
		logic                  self_addr_used;
		logic                  user_addr_sel;
		logic [1:0]            strap;
		logic [7:0]            rdata;
		logic [7:0]            segments;
	} state_t;

endpackage

/* File: tb/host_model.sv */
// host-side register master model for the decode and keyscan block
`timescale 1ns/1ps
module host_model (
	// clock
	input  wire logic                   CLOCK,
	// register access
	output led_decode_pkg::reg_access_t REG,
	input  wire logic [7:0]             REG_RDATA
);
	// ==========================================================
	// single-byte accesses with a one-cycle strobe
	initial REG = '0;
	// write one register; released fields show inverted values
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLOCK) #1;
		REG = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge CLOCK) #1;
		REG = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// read one register; data is taken after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge CLOCK) #1;
		REG = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge CLOCK) #1;
		d = REG_RDATA;
		REG = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
	endtask
endmodule // host_model

/* File: tb/test_led_decode_keyscan.sv */
// self-checking bench of the decode, keyscan and test_in_progress block
`timescale 1ns/1ps
module test_led_decode_keyscan;
	// ==========================================================
	// settings and signals
	localparam int unsigned DEB = 8;
	localparam int unsigned STEP = 2;
	localparam logic [4:0] FAC = 5'h0a; // arbitrary value
	localparam logic [4:0] USR = 5'h15; // arbitrary value
	localparam logic [111:0] FB = {7'h00, 7'h67, 7'h0e, 7'h37, 7'h4f, 7'h01, 7'h7b, 7'h7f,
		7'h70, 7'h5f, 7'h5b, 7'h33, 7'h79, 7'h6d, 7'h30, 7'h7e};
	localparam logic [111:0] FH = {7'h47, 7'h4f, 7'h3d, 7'h4e, 7'h1f, 7'h77, FB[69:0]};
	logic CLOCK, SYS_RST, RES_OPEN_SENSE, RES_SHORT_SENSE;
	logic IRQ_N_OUT, IRQ_N_OE, OPTICAL_TEST, TEST_ACTIVE;
	logic [7:0] REG_RDATA, FEATURE, DIGIT_DATA, SEGMENTS, d, dsel;
	logic [2:0] SCAN_DIGIT, TEST_DIGIT;
	logic [6:0] BUS_ADDRESS;
	led_decode_pkg::reg_access_t REG;
	led_decode_pkg::key_sense_t KEY_SENSE;
	led_decode_pkg::led_sense_t LED_SENSE;
	logic [31:0] seed;
	logic [7:0] open_test_start, short_test_start;
	int errors, check_count, cycles;

	led_decode_keyscan #(.DEBOUNCE_CYCLES(DEB), .TEST_STEP_CYCLES(STEP), .FACTORY_ADDR_BASE(FAC),
		.USER_ADDR_BASE(USR)) led_decode_keyscan_i (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .REG(REG),
		.REG_RDATA(REG_RDATA), .FEATURE(FEATURE), .SCAN_DIGIT(SCAN_DIGIT), .DIGIT_DATA(DIGIT_DATA),
		.SEGMENTS(SEGMENTS), .OPTICAL_TEST(OPTICAL_TEST), .KEY_SENSE(KEY_SENSE), .IRQ_N_OUT(IRQ_N_OUT),
		.IRQ_N_OE(IRQ_N_OE), .BUS_ADDRESS(BUS_ADDRESS), .LED_SENSE(LED_SENSE),
		.RES_OPEN_SENSE(RES_OPEN_SENSE), .RES_SHORT_SENSE(RES_SHORT_SENSE),
		.TEST_ACTIVE(TEST_ACTIVE), .TEST_DIGIT(TEST_DIGIT));
	host_model host_model_i (.CLOCK(CLOCK), .REG(REG), .REG_RDATA(REG_RDATA));
	// far-side led faults: shorts walk one segment per digit so each result lands apart
	assign LED_SENSE = '{open_fault: open_test_start, short_fault: short_test_start << TEST_DIGIT};

	// ==========================================================
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected segment drive of one digit
	function automatic logic [7:0] exp_seg(input logic [7:0] x, input logic dec, input logic hex);
		if (!dec)
			return x;
		return {x[7], hex ? FH[x[3:0]*7 +: 7] : FB[x[3:0]*7 +: 7]};
	endfunction
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask
	task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
		host_model_i.rd(a, d);
		chk_byte(d, exp);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask
	task automatic give_verdict();
		$display("checks=%0d errors=%0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ==========================================================
	// clock and hang guard
	initial
	begin
		CLOCK = 1'b0;
		forever #50 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			give_verdict();
		end
	end

	// ==========================================================
	// main sequence
	initial
	begin
		seed = 32'd33810;
		SYS_RST = 1'b1;
		FEATURE = 8'h00;
		SCAN_DIGIT = 3'h0;
		DIGIT_DATA = 8'h00;
		KEY_SENSE = 16'hffff;
		open_test_start = 8'h00;
		short_test_start = 8'h00;
		RES_OPEN_SENSE = 1'b0;
		RES_SHORT_SENSE = 1'b0;
		wait_cyc(10);
		SYS_RST = 1'b0;
		// reset values and unmapped place
		chk_byte({1'b0, BUS_ADDRESS}, 8'h00);
		chk_bit(IRQ_N_OE, 1'b0);
		chk_bit(IRQ_N_OUT, 1'b0);
		read_chk(led_decode_pkg::ADDR_DECODE_SELECT, 8'h00);
		read_chk(led_decode_pkg::ADDR_TEST_CONTROL, 8'h00);
		read_chk(led_decode_pkg::ADDR_KEY_LOW, 8'hff);
		read_chk(8'h30, 8'h00);
		// decode paths, all nibbles, both fonts
		for (int p = 0; p < 3; p++)
		begin
			dsel = (p == 0) ? 8'h25 : 8'(rnd());
			host_model_i.wr(led_decode_pkg::ADDR_DECODE_SELECT, dsel);
			for (int i = 0; i < 32; i++)
			begin
				SCAN_DIGIT = 3'(rnd());
				DIGIT_DATA = 8'(rnd() & 32'hf0) | ((i < 16) ? 8'(i) : 8'(rnd() & 32'h0f));
				FEATURE = 8'(rnd() & 32'h04);
				wait_cyc(1);
				chk_byte(SEGMENTS, exp_seg(DIGIT_DATA, dsel[SCAN_DIGIT], FEATURE[2]));
			end
			read_chk(led_decode_pkg::ADDR_DECODE_SELECT, dsel);
		end
		// debounce, interrupt and readback
		KEY_SENSE = 16'(rnd() & 32'h0000fffe);
		wait_cyc(DEB);
		chk_bit(IRQ_N_OE, 1'b0);
		wait_cyc(1);
		chk_bit(IRQ_N_OE, 1'b1);
		read_chk(led_decode_pkg::ADDR_KEY_HIGH, KEY_SENSE.high);
		wait_cyc(1);
		chk_bit(IRQ_N_OE, 1'b0);
		read_chk(led_decode_pkg::ADDR_KEY_LOW, KEY_SENSE.low);
		// no update while blinking
		FEATURE = 8'h10;
		KEY_SENSE = 16'hffff;
		wait_cyc(DEB + 4);
		chk_bit(IRQ_N_OE, 1'b0);
		FEATURE = 8'h00;
		wait_cyc(DEB + 4);
		read_chk(led_decode_pkg::ADDR_KEY_LOW, 8'hff);
		// self addressing, both address kinds
		KEY_SENSE = 16'hff5a;
		host_model_i.wr(led_decode_pkg::ADDR_BUS_CONFIG, 8'hfe);
		chk_byte({1'b0, BUS_ADDRESS}, {1'b0, FAC, 2'b10});
		host_model_i.wr(led_decode_pkg::ADDR_BUS_CONFIG, 8'h01);
		chk_byte({1'b0, BUS_ADDRESS}, {1'b0, USR, 2'b10});
		KEY_SENSE = 16'hff3c;
		wait_cyc(DEB + 4);
		read_chk(led_decode_pkg::ADDR_KEY_LOW, 8'h3f);
		read_chk(led_decode_pkg::ADDR_BUS_CONFIG, 8'h00);
		// optical test
		host_model_i.wr(led_decode_pkg::ADDR_TEST_CONTROL, 8'h01);
		wait_cyc(1);
		chk_bit(OPTICAL_TEST, 1'b1);
		chk_byte(SEGMENTS, 8'hff);
		host_model_i.wr(led_decode_pkg::ADDR_TEST_CONTROL, 8'h00);
		wait_cyc(1);
		chk_bit(OPTICAL_TEST, 1'b0);
		// open and short test with faults
		open_test_start = 8'h81;
		short_test_start = 8'h10;
		RES_OPEN_SENSE = 1'b1;
		RES_SHORT_SENSE = 1'b1;
		host_model_i.wr(led_decode_pkg::ADDR_TEST_CONTROL, 8'h06);
		chk_bit(TEST_ACTIVE, 1'b1);
		// a second start while running must be refused
		host_model_i.wr(led_decode_pkg::ADDR_TEST_CONTROL, 8'h02);
		host_model_i.rd(led_decode_pkg::ADDR_TEST_CONTROL, d);
		chk_byte(d & 8'h0e, 8'h0e);
		wait_cyc(8 * STEP + 4);
		chk_bit(TEST_ACTIVE, 1'b0);
		read_chk(led_decode_pkg::ADDR_TEST_CONTROL, 8'h76);
		read_chk(led_decode_pkg::ADDR_DIAG_FIRST, 8'h91);
		read_chk(led_decode_pkg::ADDR_DIAG_FIRST + 8'h02, 8'hc1);
		read_chk(led_decode_pkg::ADDR_DIAG_LAST, 8'h81);
		read_chk(led_decode_pkg::ADDR_DECODE_SELECT, dsel);
		// clean open-only test clears the fault flag
		open_test_start = 8'h00;
		short_test_start = 8'h00;
		host_model_i.wr(led_decode_pkg::ADDR_TEST_CONTROL, 8'h04);
		wait_cyc(8 * STEP + 4);
		read_chk(led_decode_pkg::ADDR_TEST_CONTROL, 8'h64);
		read_chk(led_decode_pkg::ADDR_DIAG_FIRST, 8'h00);
		// supply loss forgets the assigned address and the strap exclusion
		SYS_RST = 1'b1;
		wait_cyc(2);
		SYS_RST = 1'b0;
		chk_byte({1'b0, BUS_ADDRESS}, 8'h00);
		read_chk(led_decode_pkg::ADDR_DECODE_SELECT, 8'h00);
		wait_cyc(DEB + 4);
		read_chk(led_decode_pkg::ADDR_KEY_LOW, 8'h3c);
		give_verdict();
	end
endmodule // test_led_decode_keyscan
